// ===== design/retest_pkg.sv
// constants, field layouts and states of the retest protection sequencer
// assumes a byte-wide nonvolatile memory of 8 kB with a factory region at its bottom
// and a unified code/external-data RAM whose factory area sits at its top end
//
// Notes on behaviour
// - a part at the run level keeps its debug port closed unless a valid retest was entered.
// - the retest pin pattern seen at one boot step makes a run-level part without the debug-disable flag load only the factory region.
// - every action the protection flags ask for is finished before the debug port opens.
// - the protection flags are ignored unless the part is at the run level.
// - the debug-disable flag keeps the debug port closed for good and overrides every other flag.
// - the RAM-clear flag zeroes all code/external-data RAM below the factory area before opening.
// - the RAM-clear flag also zeroes internal data RAM except the lowest 8 locations.
// - the EEPROM-protect flag raises the EEPROM lock so writes stop and reads give 0x00.
// - the nonvolatile-protect flag sets the nonvolatile lock to 1 at the end of boot.
// - while nonvolatile memory is locked only the two CRC32 sums and reads of the last 64 bytes run.
// - protection options cannot be changed or added once the part is at the run level.
// - the protection byte lives at the start of the factory region with no register mirror.
// - protection bits can only go from zero to one, never back.
// - nothing lets software or a tester read the protection byte.
// - nonvolatile-protect is bit 7, EEPROM-protect bit 6 and RAM-clear bit 5 of that byte.
package retest_pkg;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int          NVM_AW            = 13;
  localparam int          XRAM_AW           = 13;
  localparam int          IRAM_AW           = 8;
  localparam logic [12:0] NVM_PROT_ADDR     = 13'h0000;
  localparam logic [12:0] NVM_LEVEL_ADDR    = 13'h0001;
  localparam logic [12:0] NVM_CHIP_ADDR     = 13'h0002;
  localparam logic [12:0] NVM_FACTORY_FIRST = 13'h0000;
  localparam logic [12:0] NVM_FACTORY_LAST  = 13'h03ff;
  localparam logic [12:0] NVM_USER_FIRST    = 13'h0400;
  localparam logic [12:0] NVM_USER_LAST     = 13'h1fbf;
  localparam logic [12:0] NVM_TAIL_FIRST    = 13'h1fc0;
  localparam logic [12:0] XRAM_FIRST        = 13'h0000;
  localparam logic [12:0] XRAM_CLEAR_LAST   = 13'h10ff;
  localparam logic [7:0]  IRAM_CLEAR_FIRST  = 8'h08;
  localparam logic [7:0]  IRAM_LAST         = 8'hff;
  localparam logic [7:0]  CLEAR_BYTE        = 8'h00;

  // ----------------------------------------------------------------
  // stored byte layouts
  // ----------------------------------------------------------------
  localparam int         NVM_LOCK_BIT  = 7;
  localparam int         EE_LOCK_BIT   = 6;
  localparam int         RAM_CLR_BIT   = 5;
  localparam int         KILL_BIT      = 0;
  localparam logic [1:0] LEVEL_FACTORY = 2'h0;
  localparam logic [1:0] LEVEL_USER    = 2'h1;
  localparam logic [1:0] LEVEL_RUN     = 2'h2;
  localparam logic [1:0] RETEST_PATTERN = 2'h2;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_ADDR     = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_RESULT   = 8'h0c;
  localparam logic [7:0] REG_PROT_ADD = 8'h10;
  localparam int         CMD_GO       = 0;
  localparam int         CMD_OP_LSB   = 1;
  localparam int         ST_BOOT_DONE = 0;
  localparam int         ST_DBG_OPEN  = 1;
  localparam int         ST_BUSY      = 2;
  localparam int         ST_REFUSED   = 3;
  localparam int         ST_NVM_LOCK  = 4;
  localparam int         ST_EE_LOCK   = 5;
  localparam int         ST_RETEST    = 6;
  localparam logic [1:0] OP_CRC_FACTORY = 2'h0;
  localparam logic [1:0] OP_CRC_USER    = 2'h1;
  localparam logic [1:0] OP_READ        = 2'h2;
  localparam logic [31:0] CRC_INIT      = 32'hffffffff;
  localparam logic [31:0] CRC_POLY      = 32'hedb88320;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [10:0] {
    ST_RD_PROT  = 11'h001,
    ST_RD_LEVEL = 11'h002,
    ST_RD_CHIP  = 11'h004,
    ST_SAMPLE   = 11'h008,
    ST_LOAD     = 11'h010,
    ST_CLR_X    = 11'h020,
    ST_CLR_I    = 11'h040,
    ST_LOCK     = 11'h080,
    ST_IDLE     = 11'h100,
    ST_CRC      = 11'h200,
    ST_XFER     = 11'h400
  } seq_state_t;

endpackage : retest_pkg

// ===== design/crc32_byte_step.sv
// one byte step of a reflected crc32
// assumes the caller holds the running value and applies the final inversion
module crc32_byte_step
  import retest_pkg::*;
(
  input  wire logic [31:0] crc_i,
  input  wire logic [7:0]  data_i,
  output logic      [31:0] crc_o
);

  always_comb begin
    logic [31:0] c;
    c = crc_i ^ {24'h000000, data_i};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    crc_o = c;
  end

endmodule : crc32_byte_step

// ===== design/retest_protection_sequencer.sv
// boot-time retest protection sequencer with an apb command port for the tester
// assumes a byte nonvolatile port that answers a held request with a one-cycle ack,
// single-cycle ram write ports and an outside loader that reports load_done_i
//
// The register addresses and register access over APB were chosen for this implementation.
module retest_protection_sequencer (
  input  wire logic                              clock_i,
  input  wire logic                              arst_n_i,
  input  wire logic [1:0]                        retest_pins_i,
  output logic                                   nvm_req_o,
  output logic                                   nvm_we_o,
  output logic [retest_pkg::NVM_AW-1:0]          nvm_addr_o,
  output logic [7:0]                             nvm_wdata_o,
  input  wire logic                              nvm_ack_i,
  input  wire logic [7:0]                        nvm_rdata_i,
  output logic                                   load_start_o,
  output logic                                   load_user_en_o,
  input  wire logic                              load_done_i,
  output logic                                   xram_we_o,
  output logic [retest_pkg::XRAM_AW-1:0]         xram_addr_o,
  output logic [7:0]                             xram_wdata_o,
  output logic                                   iram_we_o,
  output logic [retest_pkg::IRAM_AW-1:0]         iram_addr_o,
  output logic [7:0]                             iram_wdata_o,
  output logic                                   eeprom_lock_o,
  output logic                                   nvm_lock_o,
  output logic                                   debug_open_o,
  output logic                                   boot_done_o,
  input  wire logic                              psel_i,
  input  wire logic                              penable_i,
  input  wire logic                              pwrite_i,
  input  wire logic [7:0]                        paddr_i,
  input  wire logic [31:0]                       pwdata_i,
  output logic [31:0]                            prdata_o,
  output logic                                   pready_o,
  output logic                                   pslverr_o
);
  import retest_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    seq_state_t  st;
    logic [1:0]  sync0;
    logic [1:0]  sync1;
    logic [12:0] addr;
    logic [12:0] end_addr;
    logic [12:0] cmd_addr;
    logic [7:0]  prot;
    logic [7:0]  wbyte;
    logic [1:0]  level;
    logic        kill;
    logic        retest;
    logic        load_start;
    logic        boot_done;
    logic        dbg_open;
    logic        ee_lock;
    logic        nv_lock;
    logic        refused;
    logic [31:0] crc;
    logic [31:0] result;
    logic [31:0] prdata;
  } seq_regs_t;

  localparam seq_regs_t REGS_RST = '{st: ST_RD_PROT, addr: NVM_PROT_ADDR, default: '0};

  seq_regs_t   s_r;
  seq_regs_t   s_nxt;
  logic [31:0] crc_step;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic reg_mapped(input logic [7:0] a);
    return (a == REG_CMD) || (a == REG_ADDR) || (a == REG_STATUS) ||
           (a == REG_RESULT) || (a == REG_PROT_ADD);
  endfunction : reg_mapped

  function automatic logic in_tail(input logic [12:0] a);
    return a >= NVM_TAIL_FIRST;
  endfunction : in_tail

  function automatic logic [12:0] inc13(input logic [12:0] a);
    return 13'(a + 13'h0001);
  endfunction : inc13

  crc32_byte_step u_crc (
    .crc_i  (s_r.crc),
    .data_i (nvm_rdata_i),
    .crc_o  (crc_step)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        apb_wr;
    logic [31:0] status;
    logic [1:0]  op;
    s_nxt            = s_r;
    s_nxt.sync0      = retest_pins_i;
    s_nxt.sync1      = s_r.sync0;
    s_nxt.load_start = 1'b0;
    apb_wr = psel_i && penable_i && pwrite_i && reg_mapped(paddr_i);
    op     = pwdata_i[CMD_OP_LSB +: 2];

    status               = 32'h00000000;
    status[ST_BOOT_DONE] = s_r.boot_done;
    status[ST_DBG_OPEN]  = s_r.dbg_open;
    status[ST_BUSY]      = (s_r.st != ST_IDLE);
    status[ST_REFUSED]   = s_r.refused;
    status[ST_NVM_LOCK]  = s_r.nv_lock;
    status[ST_EE_LOCK]   = s_r.ee_lock;
    status[ST_RETEST]    = s_r.retest;

    // read data is caught in the setup phase so it stands through the access phase;
    // the protection byte has no read path at all
    if (psel_i && !penable_i) begin
      unique case (paddr_i)
        REG_ADDR:   s_nxt.prdata = {19'h00000, s_r.cmd_addr};
        REG_STATUS: s_nxt.prdata = status;
        REG_RESULT: s_nxt.prdata = s_r.result;
        default:    s_nxt.prdata = 32'h00000000;
      endcase
    end

    if (apb_wr && paddr_i == REG_ADDR) begin
      s_nxt.cmd_addr = pwdata_i[12:0];
    end
    // write one clears; a refusal in the same cycle below still sets it
    if (apb_wr && paddr_i == REG_STATUS && pwdata_i[ST_REFUSED]) begin
      s_nxt.refused = 1'b0;
    end

    unique case (s_r.st)
      ST_RD_PROT: begin
        if (nvm_ack_i) begin
          s_nxt.prot = nvm_rdata_i;
          s_nxt.addr = NVM_LEVEL_ADDR;
          s_nxt.st   = ST_RD_LEVEL;
        end
      end
      ST_RD_LEVEL: begin
        if (nvm_ack_i) begin
          s_nxt.level = nvm_rdata_i[1:0];
          s_nxt.addr  = NVM_CHIP_ADDR;
          s_nxt.st    = ST_RD_CHIP;
        end
      end
      ST_RD_CHIP: begin
        if (nvm_ack_i) begin
          s_nxt.kill = nvm_rdata_i[KILL_BIT];
          s_nxt.st   = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        // the only point at which the pins count; any other pattern is a normal boot
        s_nxt.retest     = (s_r.level == LEVEL_RUN) && !s_r.kill &&
                           (s_r.sync1 == RETEST_PATTERN);
        s_nxt.load_start = 1'b1;
        s_nxt.st         = ST_LOAD;
      end
      ST_LOAD: begin
        if (load_done_i) begin
          s_nxt.addr = XRAM_FIRST;
          if (s_r.retest && s_r.prot[RAM_CLR_BIT]) begin
            s_nxt.st = ST_CLR_X;
          end else begin
            s_nxt.st = ST_LOCK;
          end
        end
      end
      ST_CLR_X: begin
        // the factory area above the clear range keeps its contents
        if (s_r.addr == XRAM_CLEAR_LAST) begin
          s_nxt.addr = {5'h00, IRAM_CLEAR_FIRST};
          s_nxt.st   = ST_CLR_I;
        end else begin
          s_nxt.addr = inc13(s_r.addr);
        end
      end
      ST_CLR_I: begin
        if (s_r.addr[7:0] == IRAM_LAST) begin
          s_nxt.st = ST_LOCK;
        end else begin
          s_nxt.addr = inc13(s_r.addr);
        end
      end
      ST_LOCK: begin
        // locks settle here, one cycle ahead of the debug port opening
        s_nxt.ee_lock   = s_r.retest && s_r.prot[EE_LOCK_BIT];
        s_nxt.nv_lock   = s_r.retest && s_r.prot[NVM_LOCK_BIT];
        s_nxt.boot_done = 1'b1;
        s_nxt.st        = ST_IDLE;
      end
      ST_IDLE: begin
        s_nxt.dbg_open = !s_r.kill && ((s_r.level != LEVEL_RUN) || s_r.retest);
        if (apb_wr && paddr_i == REG_CMD && pwdata_i[CMD_GO]) begin
          if (!s_r.dbg_open) begin
            s_nxt.refused = 1'b1;
          end else if (op == OP_CRC_FACTORY) begin
            s_nxt.addr     = NVM_FACTORY_FIRST;
            s_nxt.end_addr = NVM_FACTORY_LAST;
            s_nxt.crc      = CRC_INIT;
            s_nxt.st       = ST_CRC;
          end else if (op == OP_CRC_USER) begin
            s_nxt.addr     = NVM_USER_FIRST;
            s_nxt.end_addr = NVM_USER_LAST;
            s_nxt.crc      = CRC_INIT;
            s_nxt.st       = ST_CRC;
          end else if (op == OP_READ && s_r.cmd_addr != NVM_PROT_ADDR &&
                       (!s_r.nv_lock || in_tail(s_r.cmd_addr))) begin
            // a raw read of the protection byte is refused at every level
            s_nxt.addr = s_r.cmd_addr;
            s_nxt.st   = ST_XFER;
          end else begin
            s_nxt.refused = 1'b1;
          end
        end else if (apb_wr && paddr_i == REG_PROT_ADD) begin
          // nothing may be added once the part is a run part, nor when the port is shut
          if (!s_r.dbg_open || s_r.level == LEVEL_RUN) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.wbyte = s_r.prot | pwdata_i[7:0];
            s_nxt.addr  = NVM_PROT_ADDR;
            s_nxt.st    = ST_XFER;
          end
        end
      end
      ST_CRC: begin
        if (nvm_ack_i) begin
          s_nxt.crc = crc_step;
          if (s_r.addr == s_r.end_addr) begin
            s_nxt.result = ~crc_step;
            s_nxt.st     = ST_IDLE;
          end else begin
            s_nxt.addr = inc13(s_r.addr);
          end
        end
      end
      ST_XFER: begin
        if (nvm_ack_i) begin
          if (s_r.addr == NVM_PROT_ADDR && s_r.wbyte != 8'h00) begin
            s_nxt.prot  = s_r.wbyte;
            s_nxt.wbyte = 8'h00;
          end else if (s_r.addr != NVM_PROT_ADDR) begin
            s_nxt.result = {24'h000000, nvm_rdata_i};
          end
          s_nxt.st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= REGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // a read of the protection byte during command service is blocked: the tester only
  // reaches address zero through a crc, so its raw bits never leave the block
  logic xfer_write;
  assign xfer_write = (s_r.st == ST_XFER) && (s_r.wbyte != 8'h00);

  assign nvm_req_o      = (s_r.st == ST_RD_PROT) || (s_r.st == ST_RD_LEVEL) ||
                          (s_r.st == ST_RD_CHIP) || (s_r.st == ST_CRC) || (s_r.st == ST_XFER);
  assign nvm_we_o       = xfer_write;
  assign nvm_addr_o     = s_r.addr;
  assign nvm_wdata_o    = s_r.wbyte;
  assign load_start_o   = s_r.load_start;
  assign load_user_en_o = !s_r.retest;
  assign xram_we_o      = (s_r.st == ST_CLR_X);
  assign xram_addr_o    = s_r.addr;
  assign xram_wdata_o   = CLEAR_BYTE;
  assign iram_we_o      = (s_r.st == ST_CLR_I);
  assign iram_addr_o    = s_r.addr[7:0];
  assign iram_wdata_o   = CLEAR_BYTE;
  assign eeprom_lock_o  = s_r.ee_lock;
  assign nvm_lock_o     = s_r.nv_lock;
  assign debug_open_o   = s_r.dbg_open;
  assign boot_done_o    = s_r.boot_done;
  assign prdata_o       = s_r.prdata;
  assign pready_o       = 1'b1;
  assign pslverr_o      = psel_i && penable_i && !reg_mapped(paddr_i);

endmodule : retest_protection_sequencer

// ===== dv/nvm_model.sv
// partner: byte nonvolatile memory port and boot loader
// assumes each request is held until one ack pulse is seen
module nvm_model (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        nvm_req_i,
  input  wire logic        nvm_we_i,
  input  wire logic [12:0] nvm_addr_i,
  input  wire logic [7:0]  nvm_wdata_i,
  output logic             nvm_ack_o,
  output logic      [7:0]  nvm_rdata_o,
  input  wire logic        load_start_i,
  output logic             load_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:8191];
  logic [1:0] wait_r;
  logic [2:0] load_r;
  logic       slow_r;
  // ----
  // answers alternate prompt and slow; idle data toggles
  // ----
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nvm_ack_o <= 1'b0;
      nvm_rdata_o <= 8'h00;
      wait_r <= 2'h0;
      slow_r <= 1'b0;
      load_r <= 3'h0;
      load_done_o <= 1'b0;
    end else begin
      nvm_ack_o <= 1'b0;
      nvm_rdata_o <= ~nvm_rdata_o;
      load_done_o <= (load_r == 3'h1);
      load_r <= load_start_i ? 3'h6 : load_r - {2'h0, load_r != 3'h0};
      if (nvm_req_i && !nvm_ack_o) begin
        if (wait_r != 2'h0) begin
          wait_r <= wait_r - 2'h1;
        end else begin
          nvm_ack_o <= 1'b1;
          slow_r <= !slow_r;
          wait_r <= slow_r ? 2'h0 : 2'h2;
          if (nvm_we_i) begin
            mem[nvm_addr_i] <= mem[nvm_addr_i] | nvm_wdata_i; // one-time cells only gain ones
          end else begin
            nvm_rdata_o <= mem[nvm_addr_i];
          end
        end
      end
    end
  end
endmodule : nvm_model

// ===== dv/retest_protection_sequencer_chk.sv
// concurrent checks on the retest protection sequencer
// assumes it is bound to the sequencer top by port name
module retest_protection_sequencer_chk (
  input wire logic                            clock_i,
  input wire logic                            arst_n_i,
  input wire logic                            nvm_req_o,
  input wire logic                            nvm_we_o,
  input wire logic [retest_pkg::NVM_AW-1:0]   nvm_addr_o,
  input wire logic                            nvm_ack_i,
  input wire logic                            xram_we_o,
  input wire logic [retest_pkg::XRAM_AW-1:0]  xram_addr_o,
  input wire logic [7:0]                      xram_wdata_o,
  input wire logic                            iram_we_o,
  input wire logic [retest_pkg::IRAM_AW-1:0]  iram_addr_o,
  input wire logic [7:0]                      iram_wdata_o,
  input wire logic                            eeprom_lock_o,
  input wire logic                            nvm_lock_o,
  input wire logic                            debug_open_o,
  input wire logic                            boot_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  open_after_boot_a : assert property (
    debug_open_o |-> boot_done_o) else $error("debug open before boot end");
  closed_clearing_a : assert property (
    xram_we_o || iram_we_o |-> !debug_open_o && !boot_done_o) else $error("open while clearing");
  xram_zero_a : assert property (
    xram_we_o |-> xram_wdata_o == 8'h00 && xram_addr_o <= 13'h10ff) else $error("bad code ram clear");
  xram_walk_a : assert property (
    xram_we_o |-> ($rose(xram_we_o) ? xram_addr_o == 13'h0 : xram_addr_o == $past(xram_addr_o) + 13'h1))
    else $error("code ram clear skips");
  iram_zero_a : assert property (
    iram_we_o |-> iram_wdata_o == 8'h00 && iram_addr_o >= 8'h08) else $error("bad data ram clear");
  iram_follows_a : assert property (
    $fell(xram_we_o) |-> ##[0:2] iram_we_o) else $error("data ram clear missing");
  nvm_lock_end_a : assert property (
    $rose(nvm_lock_o) |-> $rose(boot_done_o)) else $error("nvm lock not at boot end");
  locks_stick_a : assert property (
    !$fell(eeprom_lock_o) && !$fell(nvm_lock_o)) else $error("lock released");
  nvm_hold_a : assert property (
    nvm_req_o && !nvm_ack_i |=> nvm_req_o && $stable(nvm_addr_o)) else $error("nvm request dropped");
  prot_write_a : assert property (
    nvm_req_o && nvm_we_o |-> debug_open_o && nvm_addr_o == 13'h0) else $error("bad nvm write");
endmodule : retest_protection_sequencer_chk

bind retest_protection_sequencer retest_protection_sequencer_chk i_chk (.clock_i, .arst_n_i, .nvm_req_o,
  .nvm_we_o, .nvm_addr_o, .nvm_ack_i, .xram_we_o, .xram_addr_o, .xram_wdata_o, .iram_we_o, .iram_addr_o,
  .iram_wdata_o, .eeprom_lock_o, .nvm_lock_o, .debug_open_o, .boot_done_o);

// ===== dv/retest_protection_sequencer_tb.sv
// self-checking bench for the retest protection sequencer
// assumes the nvm_model partner and the bound checker
module retest_protection_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import retest_pkg::*;
  logic        clock_i = 1'b0, arst_n_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [1:0]  retest_pins_i = 2'h0;
  logic [7:0]  paddr_i = 8'h00, nvm_wdata_o, nvm_rdata_i, xram_wdata_o, iram_wdata_o, iram_addr_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [12:0] nvm_addr_o, xram_addr_o;
  logic        nvm_req_o, nvm_we_o, nvm_ack_i, load_start_o, load_user_en_o, load_done_i, xram_we_o;
  logic        iram_we_o, eeprom_lock_o, nvm_lock_o, debug_open_o, boot_done_o, pready_o, pslverr_o;
  logic        user_en, slverr;
  int          fails = 0, compares = 0, cycles = 0, xram_n, iram_n, wr_n;

  retest_protection_sequencer i_dut (.clock_i, .arst_n_i, .retest_pins_i, .nvm_req_o, .nvm_we_o, .nvm_addr_o,
    .nvm_wdata_o, .nvm_ack_i, .nvm_rdata_i, .load_start_o, .load_user_en_o, .load_done_i, .xram_we_o,
    .xram_addr_o, .xram_wdata_o, .iram_we_o, .iram_addr_o, .iram_wdata_o, .eeprom_lock_o, .nvm_lock_o,
    .debug_open_o, .boot_done_o, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o);
  nvm_model i_nvm (.clock_i, .arst_n_i, .nvm_req_i(nvm_req_o), .nvm_we_i(nvm_we_o), .nvm_addr_i(nvm_addr_o),
    .nvm_wdata_i(nvm_wdata_o), .nvm_ack_o(nvm_ack_i), .nvm_rdata_o(nvm_rdata_i), .load_start_i(load_start_o),
    .load_done_o(load_done_i));

  always #5 clock_i = ~clock_i;
  // ----
  // monitors; the cycle ceiling covers the long user checksum
  // ----
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    // counters clear while reset is low, so no race with the scenario tasks
    if (!arst_n_i) begin
      xram_n <= 0;
      iram_n <= 0;
      wr_n <= 0;
    end else begin
      xram_n <= xram_n + int'(xram_we_o);
      iram_n <= iram_n + int'(iram_we_o);
      wr_n <= wr_n + int'(nvm_req_o && nvm_we_o && nvm_ack_i);
    end
    if (load_start_o) begin
      user_en <= load_user_en_o;
    end
    if (cycles == 60000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] crc_ref(input logic [12:0] first, input logic [12:0] last);
    logic [31:0] c;
    c = CRC_INIT;
    for (int a = first; a <= last; a++) begin
      c = c ^ {24'h0, i_nvm.mem[a]};
      for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction : crc_ref

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    slverr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask : apb

  task automatic cmd(input logic [31:0] c);
    apb(1'b1, REG_CMD, c);
    for (int n = 0; n < 12000; n++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rd[ST_BUSY] === 1'b0) break;
    end
  endtask : cmd

  task automatic boot(input logic [7:0] prot, input logic [1:0] lvl, input logic kill, input logic [1:0] pins);
    i_nvm.mem[0] = prot;
    i_nvm.mem[1] = {6'h0, lvl};
    i_nvm.mem[2] = {7'h0, kill};
    retest_pins_i <= pins;
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    for (int n = 0; n < 6000 && boot_done_o !== 1'b1; n++) @(posedge clock_i);
    repeat (2) @(posedge clock_i);
    apb(1'b0, REG_STATUS, 32'h0);
  endtask : boot

  task automatic t_retest;
    boot(8'he0, LEVEL_RUN, 1'b0, RETEST_PATTERN);
    chk("status", 32'h73, rd);
    chk("xram_clears", 4352, xram_n);
    chk("iram_clears", 248, iram_n);
    chk("user_load", 0, user_en);
    chk("lock_pins", 3, {eeprom_lock_o, nvm_lock_o});
    apb(1'b1, REG_ADDR, 32'h1fc5);
    cmd(32'h5);
    chk("tail_refused", 0, rd[ST_REFUSED]);
    apb(1'b0, REG_RESULT, 32'h0);
    chk("tail_byte", {24'h0, i_nvm.mem[13'h1fc5]}, rd);
    apb(1'b1, REG_ADDR, 32'h1fbf);
    cmd(32'h5);
    chk("locked_read", 1, rd[ST_REFUSED]);
    apb(1'b1, REG_STATUS, 32'h8);
    for (int op = 0; op < 4; op += 1 + int'(op == 1)) begin
      cmd({29'h0, op[1:0], 1'b1});
      chk("op_refused", op == 3, rd[ST_REFUSED]);
      if (op < 2) begin
        apb(1'b0, REG_RESULT, 32'h0);
        chk("crc", (op == 0) ? crc_ref(NVM_FACTORY_FIRST, NVM_FACTORY_LAST)
                             : crc_ref(NVM_USER_FIRST, NVM_USER_LAST), rd);
      end
    end
    apb(1'b1, REG_STATUS, 32'h8);
    apb(1'b1, REG_PROT_ADD, 32'h10);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("add_refused", 1, rd[ST_REFUSED]);
    chk("prot_writes", 0, wr_n);
  endtask : t_retest

  task automatic t_plain(input logic [1:0] lvl, input logic kill, input logic [1:0] pins, input logic [31:0] st);
    boot(8'he0, lvl, kill, pins);
    chk("status", st, rd);
    chk("ram_clears", 0, xram_n + iram_n);
    chk("user_load", 1, user_en);
    chk("lock_pins", 0, {eeprom_lock_o, nvm_lock_o});
    chk("debug_pin", st[ST_DBG_OPEN], debug_open_o);
    apb(1'b1, REG_ADDR, 32'h1fc5);
    cmd(32'h5);
    chk("cmd_refused", !st[ST_DBG_OPEN], rd[ST_REFUSED]);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 1, slverr);
  endtask : t_plain

  task automatic t_add;
    apb(1'b1, REG_PROT_ADD, 32'h04);
    for (int n = 0; n < 50 && wr_n == 0; n++) @(posedge clock_i);
    chk("prot_byte", 8'he4, i_nvm.mem[0]);
    apb(1'b0, REG_PROT_ADD, 32'h0);
    chk("prot_hidden", 0, rd);
    apb(1'b1, REG_ADDR, 32'h0);
    cmd(32'h5);
    chk("prot_read_refused", 1, rd[ST_REFUSED]);
  endtask : t_add

  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    for (int i = 0; i < 8192; i++) i_nvm.mem[i] = i[7:0] ^ 8'h5a;
    t_retest();
    $display("test retest done");
    t_plain(LEVEL_RUN, 1'b0, 2'h1, 32'h01);
    $display("test normal boot done");
    t_plain(LEVEL_RUN, 1'b1, RETEST_PATTERN, 32'h01);
    $display("test debug kill done");
    t_plain(LEVEL_USER, 1'b0, RETEST_PATTERN, 32'h03);
    t_add();
    $display("test user level done");
    end_of_test();
  end
endmodule : retest_protection_sequencer_tb
